// ===== design/timer16_capture_compare.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Read-only 16-bit counter, increments per count step
// - Reset forces count to zero
// - Mode bits both zero clears, stops count
// - Edge-clear mode: primary edge clears count
// - Match-clear mode: compare equality clears count
// - One-shot trigger write clears count
// - Control bit 0 picks capture or compare
// - Compare register resets zero, whole writes
// - Compare role: equality raises match interrupt
// - Primary source captures on opposite edge
// - Secondary source captures on selected edge
// - Edge fields in prescaler bits 7..4
// - Zero compare fires on 0000 to 0001
// - Shared pin is input or output, not both
// - Read during capture may be undefined
// - Capture while stopping may be undefined
// - Interval timer interrupts each programmed interval
// - External pulses can be counted
// - Programmable-width single pulse output
// - Counting starts on nonzero mode, stops zero
module timer16_capture_compare #(
  parameter int DIV_WIDTH = 4   // Width of prescaler divider
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  input  wire logic        primary_timer_input,
  input  wire logic        shared_port_pin_in,
  output logic             shared_port_pin_out,
  output logic             shared_port_pin_oe,
  output logic             match_capture_irq
);
  // Reset release chain
  logic rst_meta_reg;
  logic rst_n;

  // Software-visible registers and internal state
  logic [15:0] count_reg;          // Counter value
  logic [15:0] cc_first_reg;       // Capture/compare value
  logic [3:0]  mode_ctrl_reg;      // Mode select, toggle, overflow
  logic [1:0]  cc_ctrl_reg;        // Role and source select
  logic [7:0]  prescale_reg;       // Edge selects and count clock
  logic [1:0]  out_ctrl_reg;       // Output enable, one-shot enable
  logic        irq_flag_reg;       // Sticky match/capture status
  logic        out_level_reg;      // Waveform output level
  logic        oneshot_active_reg; // One-shot pulse in progress
  logic        wrap_armed_reg;     // Counter wrapped, waiting for 0001
  logic [DIV_WIDTH-1:0] div_reg;   // Prescaler divider
  logic [15:0] rdata_reg;          // Read data, one cycle later

  // Decoded controls
  timer16_pkg::mode_type mode;
  logic       running;
  logic       role_capture;
  logic       src_primary;
  logic [1:0] pri_edge;
  logic [1:0] sec_edge;
  logic [1:0] div_sel;
  logic       step;                // One-cycle count enable
  logic       pri_rise;
  logic       pri_fall;
  logic       sec_rise;
  logic       sec_fall;
  logic       pri_valid;           // Primary valid edge per select
  logic       sec_valid;           // Secondary valid edge per select
  logic       stop_write;          // Software clears both mode bits
  logic       capture_trig;
  logic       match_hit;
  logic       wrap_event;
  logic       clear_count;
  logic       trigger_write;
  logic       irq_event;
  logic       match_clear_mode;

  // Release reset through two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Input synchronisers and edge detectors
  timer16_edge_detect pri_detect (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .pin_in     (primary_timer_input),
    .rise_pulse (pri_rise),
    .fall_pulse (pri_fall)
  );

  timer16_edge_detect sec_detect (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .pin_in     (shared_port_pin_in),
    .rise_pulse (sec_rise),
    .fall_pulse (sec_fall)
  );

  // Field decode
  always_comb begin
    case ({mode_ctrl_reg[timer16_pkg::MODE_SEL3_BIT], mode_ctrl_reg[timer16_pkg::MODE_SEL2_BIT]})
      2'h0:    mode = timer16_pkg::MODE_STOP;
      2'h1:    mode = timer16_pkg::MODE_FREE;
      2'h2:    mode = timer16_pkg::MODE_EDGE_CLEAR;
      2'h3:    mode = timer16_pkg::MODE_MATCH_CLEAR;
      default: mode = timer16_pkg::MODE_STOP;
    endcase
  end

  assign running          = (mode != timer16_pkg::MODE_STOP);
  assign match_clear_mode = (mode == timer16_pkg::MODE_MATCH_CLEAR);
  assign role_capture     = cc_ctrl_reg[timer16_pkg::CC_ROLE_BIT];
  assign src_primary      = cc_ctrl_reg[timer16_pkg::CC_SRC_BIT];
  assign pri_edge         = prescale_reg[timer16_pkg::PRI_EDGE_LO +: 2];
  assign sec_edge         = prescale_reg[timer16_pkg::SEC_EDGE_LO +: 2];
  assign div_sel          = prescale_reg[timer16_pkg::PRE_DIV_LO +: 2];

  // Count clock: divider output, or secondary valid edges for event counting
  always_comb begin
    case (div_sel)
      2'h0:    step = running;
      2'h1:    step = running & (div_reg[0] == 1'b1);
      2'h2:    step = running & (&div_reg);
      2'h3:    step = running & sec_valid & ~out_ctrl_reg[timer16_pkg::OUT_ENABLE_BIT];
      default: step = 1'b0;
    endcase
  end

  // Primary valid edge per its select; code 10 is never programmed
  always_comb begin
    case (pri_edge)
      timer16_pkg::EDGE_FALL: pri_valid = pri_fall;
      timer16_pkg::EDGE_RISE: pri_valid = pri_rise;
      timer16_pkg::EDGE_BOTH: pri_valid = pri_rise | pri_fall;
      default:                pri_valid = 1'b0;
    endcase
  end

  // Secondary valid edge; one counted pulse per selected edge, not two
  always_comb begin
    case (sec_edge)
      timer16_pkg::EDGE_FALL: sec_valid = sec_fall;
      timer16_pkg::EDGE_RISE: sec_valid = sec_rise;
      timer16_pkg::EDGE_BOTH: sec_valid = sec_rise | sec_fall;
      default:                sec_valid = 1'b0;
    endcase
  end

  // Capture trigger selection
  always_comb begin
    capture_trig = 1'b0;
    if (role_capture) begin
      if (src_primary) begin
        case (pri_edge)
          timer16_pkg::EDGE_RISE: capture_trig = pri_fall;
          timer16_pkg::EDGE_FALL: capture_trig = pri_rise;
          default:                capture_trig = 1'b0;
        endcase
      end else if (!out_ctrl_reg[timer16_pkg::OUT_ENABLE_BIT]) begin
        case (sec_edge)
          timer16_pkg::EDGE_FALL: capture_trig = sec_fall;
          timer16_pkg::EDGE_RISE: capture_trig = sec_rise;
          timer16_pkg::EDGE_BOTH: capture_trig = sec_rise | sec_fall;
          default:                capture_trig = 1'b0;
        endcase
      end
    end
  end

  // Compare hit on a count step; zero value fires only after a wrap
  assign match_hit  = ~role_capture & step & (count_reg == cc_first_reg)
                      & (cc_first_reg != timer16_pkg::COUNT_RESET);
  assign wrap_event = ~role_capture & step & wrap_armed_reg
                      & (cc_first_reg == timer16_pkg::COUNT_RESET)
                      & (count_reg == timer16_pkg::COUNT_RESET);
  assign irq_event  = match_hit | wrap_event | (capture_trig & running);

  // One-shot trigger write
  assign trigger_write = reg_write & (reg_addr == timer16_pkg::ADDR_OUT_CTRL)
                         & reg_wdata[timer16_pkg::OUT_TRIGGER_BIT]
                         & out_ctrl_reg[timer16_pkg::OUT_ONESHOT_BIT];

  // Stop write clears at once, so a read right after it sees zero
  assign stop_write = reg_write & (reg_addr == timer16_pkg::ADDR_MODE_CTRL)
                      & ~reg_wdata[timer16_pkg::MODE_SEL3_BIT]
                      & ~reg_wdata[timer16_pkg::MODE_SEL2_BIT];

  // Trigger, edge and match clear sources for the counter; stop is handled in the counter
  assign clear_count = trigger_write
                     | ((mode == timer16_pkg::MODE_EDGE_CLEAR) & pri_valid)
                     | (match_clear_mode & match_hit);

  // Prescaler divider, free while running
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else if (!running) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // Counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= timer16_pkg::COUNT_RESET;
    end else if (!running || stop_write) begin
      count_reg <= timer16_pkg::COUNT_RESET;
    end else if (clear_count) begin
      count_reg <= timer16_pkg::COUNT_RESET;
    end else if (step) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // Wrap tracker for the zero-compare case
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrap_armed_reg <= 1'b0;
    end else if (!running) begin
      wrap_armed_reg <= 1'b0;
    end else if (step && count_reg == timer16_pkg::COUNT_MAX) begin
      wrap_armed_reg <= 1'b1;
    end else if (step && count_reg == timer16_pkg::COUNT_RESET) begin
      wrap_armed_reg <= 1'b0;
    end
  end

  // Capture/compare register: software write or capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cc_first_reg <= timer16_pkg::COUNT_RESET;
    end else if (capture_trig) begin
      cc_first_reg <= count_reg;
    end else if (reg_write && reg_addr == timer16_pkg::ADDR_CC_FIRST) begin
      cc_first_reg <= reg_wdata;
    end
  end

  // Control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ctrl_reg <= timer16_pkg::CTRL_RESET[3:0];
      cc_ctrl_reg   <= timer16_pkg::CTRL_RESET[1:0];
      prescale_reg  <= timer16_pkg::CTRL_RESET;
      out_ctrl_reg  <= timer16_pkg::CTRL_RESET[1:0];
    end else begin
      // Overflow flag: hardware set wins over software clear
      if (reg_write && reg_addr == timer16_pkg::ADDR_MODE_CTRL) begin
        mode_ctrl_reg <= reg_wdata[3:0];
      end
      if (step && count_reg == timer16_pkg::COUNT_MAX && !clear_count) begin
        mode_ctrl_reg[timer16_pkg::MODE_OVF_BIT] <= 1'b1;
      end
      if (reg_write && reg_addr == timer16_pkg::ADDR_CC_CTRL) begin
        cc_ctrl_reg <= reg_wdata[1:0];
      end
      if (reg_write && reg_addr == timer16_pkg::ADDR_PRESCALE) begin
        prescale_reg <= reg_wdata[7:0];
      end
      if (reg_write && reg_addr == timer16_pkg::ADDR_OUT_CTRL) begin
        out_ctrl_reg <= reg_wdata[1:0];
      end
    end
  end

  // Sticky status; set wins over write-one-to-clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_reg <= 1'b0;
    end else if (irq_event) begin
      irq_flag_reg <= 1'b1;
    end else if (reg_write && reg_addr == timer16_pkg::ADDR_STATUS && reg_wdata[0]) begin
      irq_flag_reg <= 1'b0;
    end
  end

  // Interrupt pulse registered from the event
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_capture_irq <= 1'b0;
    end else begin
      match_capture_irq <= irq_event;
    end
  end

  // Waveform output: toggles on match, optional input edge, one-shot
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_level_reg      <= 1'b0;
      oneshot_active_reg <= 1'b0;
    end else if (!running) begin
      out_level_reg      <= 1'b0;
      oneshot_active_reg <= 1'b0;
    end else if (out_ctrl_reg[timer16_pkg::OUT_ONESHOT_BIT]) begin
      // Width is the distance from trigger to compare match
      if (trigger_write) begin
        out_level_reg      <= 1'b1;
        oneshot_active_reg <= 1'b1;
      end else if (oneshot_active_reg && match_hit) begin
        out_level_reg      <= 1'b0;
        oneshot_active_reg <= 1'b0;
      end
    end else if (match_hit || (mode_ctrl_reg[timer16_pkg::MODE_TOGGLE_BIT] && pri_valid)) begin
      out_level_reg <= ~out_level_reg;
    end
  end

  // Shared pin drives only when chosen as output
  assign shared_port_pin_out = out_level_reg;
  assign shared_port_pin_oe  = out_ctrl_reg[timer16_pkg::OUT_ENABLE_BIT];

  // Read mux; unmapped addresses read zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (reg_read) begin
      case (reg_addr)
        timer16_pkg::ADDR_COUNT:     rdata_reg <= count_reg;
        timer16_pkg::ADDR_CC_FIRST:  rdata_reg <= cc_first_reg;
        timer16_pkg::ADDR_MODE_CTRL: rdata_reg <= {12'h000, mode_ctrl_reg};
        timer16_pkg::ADDR_CC_CTRL:   rdata_reg <= {14'h0000, cc_ctrl_reg};
        timer16_pkg::ADDR_PRESCALE:  rdata_reg <= {8'h00, prescale_reg};
        timer16_pkg::ADDR_OUT_CTRL:  rdata_reg <= {14'h0000, out_ctrl_reg};
        timer16_pkg::ADDR_STATUS:    rdata_reg <= {15'h0000, irq_flag_reg};
        default:                     rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule : timer16_capture_compare
`default_nettype wire

// ===== design/timer16_pkg.sv
package timer16_pkg;
  // Register addresses (byte addresses, word wide)
  localparam logic [15:0] ADDR_COUNT      = 16'hFF10;  // Count value, read only
  localparam logic [15:0] ADDR_CC_FIRST   = 16'hFF12;  // Capture/compare register
  localparam logic [15:0] ADDR_MODE_CTRL  = 16'hFF20;  // Mode control
  localparam logic [15:0] ADDR_CC_CTRL    = 16'hFF22;  // Capture/compare control
  localparam logic [15:0] ADDR_PRESCALE   = 16'hFF24;  // Prescaler mode
  localparam logic [15:0] ADDR_OUT_CTRL   = 16'hFF26;  // Output control
  localparam logic [15:0] ADDR_STATUS     = 16'hFF28;  // Status, write one to clear

  // Mode control fields
  localparam int MODE_OVF_BIT     = 0;   // Overflow flag
  localparam int MODE_TOGGLE_BIT  = 1;   // Toggle output on input edge too
  localparam int MODE_SEL2_BIT    = 2;   // Mode select low
  localparam int MODE_SEL3_BIT    = 3;   // Mode select high
  // Capture/compare control fields
  localparam int CC_ROLE_BIT      = 0;   // 1 = capture, 0 = compare
  localparam int CC_SRC_BIT       = 1;   // 1 = primary input opposite edge
  // Prescaler mode fields
  localparam int PRE_DIV_LO       = 0;   // Count clock select, two bits
  localparam int PRI_EDGE_LO      = 4;   // Primary edge select low
  localparam int SEC_EDGE_LO      = 6;   // Secondary edge select low
  // Output control fields
  localparam int OUT_ENABLE_BIT   = 0;   // Shared pin used as output
  localparam int OUT_ONESHOT_BIT  = 1;   // One-shot pulse mode enable
  localparam int OUT_TRIGGER_BIT  = 2;   // One-shot trigger, self clearing

  // Edge select encodings
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Operating modes from the two select bits
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_FREE,
    MODE_EDGE_CLEAR,
    MODE_MATCH_CLEAR
  } mode_type;

  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE   = 16'h0001;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
endpackage : timer16_pkg

// ===== design/timer16_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with rise/fall pulses taken from the second stage
module timer16_edge_detect (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      rise_pulse,
  output logic      fall_pulse
);
  logic meta_reg;   // First stage, read only by sync_reg
  logic sync_reg;   // Second stage
  logic last_reg;   // Previous synchronised level

  // Synchroniser chain and history
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // One pulse per transition
  assign rise_pulse = sync_reg & ~last_reg;
  assign fall_pulse = ~sync_reg & last_reg;
endmodule : timer16_edge_detect
`default_nettype wire

// ===== tb/timer16_capture_compare_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the timer block
module timer16_capture_compare_checker #(
  parameter int DIV_WIDTH = 4  // Same divider width as the block
) (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic        primary_timer_input,
  input wire logic        shared_port_pin_in,
  input wire logic        shared_port_pin_out,
  input wire logic        shared_port_pin_oe,
  input wire logic        match_capture_irq
);
  logic mapped;  // Address hits a register
  logic wr_out;  // Write to output control
  assign mapped = reg_addr inside {timer16_pkg::ADDR_COUNT, timer16_pkg::ADDR_CC_FIRST,
    timer16_pkg::ADDR_MODE_CTRL, timer16_pkg::ADDR_CC_CTRL, timer16_pkg::ADDR_PRESCALE,
    timer16_pkg::ADDR_OUT_CTRL, timer16_pkg::ADDR_STATUS};
  assign wr_out = reg_write && reg_addr == timer16_pkg::ADDR_OUT_CTRL;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Outputs quiet while reset is low; needs its own disable
  reset_quiet_a: assert property (disable iff (1'b0) !nrst |->
    !match_capture_irq && !shared_port_pin_oe && reg_rdata == 16'h0000)
    else $error("output active in reset");
  idle_rdata_zero_a: assert property (!reg_read |=> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  unmapped_zero_a: assert property (reg_read && !mapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  // Pin direction comes only from software
  oe_follows_write_a: assert property (wr_out |=> shared_port_pin_oe == $past(reg_wdata[0]))
    else $error("output enable not taken");
  oe_holds_a: assert property (!wr_out |=> $stable(shared_port_pin_oe))
    else $error("output enable moved");
  irq_one_cycle_a: assert property (match_capture_irq |=> !match_capture_irq)
    else $error("interrupt longer than a cycle");
  // Stop write then count read must see zero
  stop_clears_a: assert property (reg_write && reg_addr == timer16_pkg::ADDR_MODE_CTRL &&
    reg_wdata[3:2] == 2'h0 ##1 reg_read && reg_addr == timer16_pkg::ADDR_COUNT
    |=> reg_rdata == 16'h0000)
    else $error("stopped count not zero");
  status_sets_a: assert property (match_capture_irq && !reg_write ##1 reg_read &&
    reg_addr == timer16_pkg::ADDR_STATUS |=> reg_rdata[0])
    else $error("status flag missed interrupt");
  status_clears_a: assert property (reg_write && reg_addr == timer16_pkg::ADDR_STATUS &&
    reg_wdata[0] && !match_capture_irq ##1 reg_read && reg_addr == timer16_pkg::ADDR_STATUS &&
    !match_capture_irq |=> !reg_rdata[0])
    else $error("status flag not cleared");
endmodule : timer16_capture_compare_checker

bind timer16_capture_compare timer16_capture_compare_checker #(.DIV_WIDTH(DIV_WIDTH)) chk (
  .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .primary_timer_input(primary_timer_input), .shared_port_pin_in(shared_port_pin_in),
  .shared_port_pin_out(shared_port_pin_out), .shared_port_pin_oe(shared_port_pin_oe),
  .match_capture_irq(match_capture_irq));
`default_nettype wire

// ===== tb/timer16_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
// External pulse sources and the shared pin wire
module timer16_pin_partner (
  input  wire logic sys_clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      primary_level,
  output logic      shared_level
);
  logic sec_drive;  // Source level on the shared pin

  initial begin
    primary_level = 1'b0;
    sec_drive     = 1'b0;
  end
  // Block owns the wire when enabled, source otherwise
  assign shared_level = pin_oe ? pin_out : sec_drive;

  // Levels change just after an edge and are held for many cycles
  task automatic drive(input logic primary, input logic level);
    @(posedge sys_clk);
    if (primary) begin
      primary_level <= level;
    end else begin
      sec_drive <= level;
    end
  endtask : drive
endmodule : timer16_pin_partner
`default_nettype wire

// ===== tb/test_timer16_capture_compare.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_timer16_capture_compare;
  logic        sys_clk   = 1'b0;     // Bench clock
  logic        nrst;                 // Reset, driven low at time zero
  logic [15:0] reg_addr  = 16'h0000; // Bus address
  logic [15:0] reg_wdata = 16'h0000; // Bus write data
  logic        reg_write = 1'b0;     // Write strobe
  logic        reg_read  = 1'b0;     // Read strobe
  logic [15:0] reg_rdata;            // Read data
  logic        prim_pin;             // Primary input level
  logic        shared_pin;           // Resolved shared pin
  logic        pin_out;              // Block drive of shared pin
  logic        pin_oe;               // Block enable of shared pin
  logic        irq;                  // Interrupt pulse
  logic [15:0] d1;                   // First read result
  logic [15:0] d2;                   // Second read result
  int          fail_count = 0;       // Mismatches
  int          tests_run  = 0;       // Comparisons
  int          irq_seen   = 0;       // Interrupt pulses counted
  logic [1:0]  codes [6]    = '{2'h1, 2'h0, 2'h3, 2'h0, 2'h1, 2'h3};
  int          rise_exp [6] = '{0, 1, 0, 0, 1, 1};
  int          fall_exp [6] = '{1, 1, 0, 1, 1, 2};

  always #12.5 sys_clk = ~sys_clk;
  // Count pulses as they are sampled
  always @(posedge sys_clk) if (irq === 1'b1) irq_seen++;

  timer16_capture_compare #(.DIV_WIDTH(4)) DUT (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .primary_timer_input(prim_pin), .shared_port_pin_in(shared_pin),
    .shared_port_pin_out(pin_out), .shared_port_pin_oe(pin_oe), .match_capture_irq(irq));
  timer16_pin_partner ext (
    .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .primary_level(prim_pin), .shared_level(shared_pin));

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  // Read or write, then a read in the very next cycle
  task automatic pair(input logic w, input logic [15:0] a1, input logic [15:0] wd,
                      input logic [15:0] a2, output logic [15:0] r1, output logic [15:0] r2);
    @(posedge sys_clk);
    reg_write <= w;
    reg_read  <= !w;
    reg_addr  <= a1;
    reg_wdata <= wd;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    reg_addr  <= a2;
    #1 r1 = reg_rdata;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 r2 = reg_rdata;
  endtask : pair
  // Stop first; setup is only legal while stopped
  task automatic cfg(input logic [15:0] cc, input logic [15:0] pre);
    wr(timer16_pkg::ADDR_MODE_CTRL, 16'h0000);
    wr(timer16_pkg::ADDR_CC_CTRL, cc);
    wr(timer16_pkg::ADDR_PRESCALE, pre);
    wr(timer16_pkg::ADDR_CC_FIRST, 16'h0000);
  endtask : cfg
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // Watchdog well past the longest run
  initial begin
    repeat (90000) @(posedge sys_clk);
    fail_count++;
    stop_test;
  end

  initial begin
    nrst <= 1'b0;  // Non-blocking so the async reset sees a real edge
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // Reset values, read-only counter, unmapped place
    pair(1'b0, timer16_pkg::ADDR_COUNT, 16'h0000, timer16_pkg::ADDR_CC_FIRST, d1, d2);
    `CHK(d1, 16'h0000)
    `CHK(d2, 16'h0000)
    wr(timer16_pkg::ADDR_COUNT, 16'h1234);
    pair(1'b0, 16'hFF30, 16'h0000, timer16_pkg::ADDR_COUNT, d1, d2);
    `CHK(d1, 16'h0000)
    `CHK(d2, 16'h0000)
    // Free run steps by one, stop clears
    wr(timer16_pkg::ADDR_MODE_CTRL, 16'h0004);
    pair(1'b0, timer16_pkg::ADDR_COUNT, 16'h0000, timer16_pkg::ADDR_COUNT, d1, d2);
    `CHK(d2, d1 + 16'h0001)
    pair(1'b1, timer16_pkg::ADDR_MODE_CTRL, 16'h0000, timer16_pkg::ADDR_COUNT, d1, d2);
    `CHK(d2, 16'h0000)
    wr(timer16_pkg::ADDR_CC_FIRST, 16'hA5C3);
    pair(1'b0, timer16_pkg::ADDR_CC_FIRST, 16'h0000, timer16_pkg::ADDR_COUNT, d1, d2);
    `CHK(d1, 16'hA5C3)
    `CHK(d2, 16'h0000)
    // Match clear at 7: period of eight
    cfg(16'h0000, 16'h0000);
    wr(timer16_pkg::ADDR_CC_FIRST, 16'h0007);
    wr(timer16_pkg::ADDR_MODE_CTRL, 16'h000C);
    repeat (20) @(posedge sys_clk);
    #1 irq_seen = 0;
    repeat (80) @(posedge sys_clk);
    #1 `CHK(irq_seen, 10)
    for (int i = 0; i < 8; i++) begin
      pair(1'b0, timer16_pkg::ADDR_COUNT, 16'h0000, timer16_pkg::ADDR_STATUS, d1, d2);
      `CHK(d1 > 16'h0007, 1'b0)
      `CHK(d2[0], 1'b1)
    end
    wr(timer16_pkg::ADDR_MODE_CTRL, 16'h0000);
    pair(1'b1, timer16_pkg::ADDR_STATUS, 16'h0001, timer16_pkg::ADDR_STATUS, d1, d2);
    `CHK(d2[0], 1'b0)
    pair(1'b0, timer16_pkg::ADDR_CC_FIRST, 16'h0000, timer16_pkg::ADDR_CC_FIRST, d1, d2);
    `CHK(d1, 16'h0007)
    // Zero compare fires only after the wrap
    wr(timer16_pkg::ADDR_CC_FIRST, 16'h0000);
    wr(timer16_pkg::ADDR_MODE_CTRL, 16'h0004);
    #1 irq_seen = 0;
    repeat (100) @(posedge sys_clk);
    #1 `CHK(irq_seen, 0)
    repeat (65536) @(posedge sys_clk);
    #1 `CHK(irq_seen, 1)
    // Every edge code on both capture sources
    for (int i = 0; i < 6; i++) begin
      cfg(i < 3 ? 16'h0003 : 16'h0001, 16'(codes[i]) << (i < 3 ? 4 : 6));
      wr(timer16_pkg::ADDR_MODE_CTRL, 16'h0004);
      #1 irq_seen = 0;
      ext.drive(i < 3, 1'b1);
      repeat (6) @(posedge sys_clk);
      #1 `CHK(irq_seen, rise_exp[i])
      ext.drive(i < 3, 1'b0);
      repeat (6) @(posedge sys_clk);
      #1 `CHK(irq_seen, fall_exp[i])
      pair(1'b0, timer16_pkg::ADDR_CC_FIRST, 16'h0000, timer16_pkg::ADDR_CC_FIRST, d1, d2);
      `CHK(d1 === 16'h0000, fall_exp[i] == 0)
    end
    // Primary rising edge restarts the count
    cfg(16'h0000, 16'h0010);
    wr(timer16_pkg::ADDR_MODE_CTRL, 16'h0008);
    repeat (200) @(posedge sys_clk);
    ext.drive(1'b1, 1'b1);
    repeat (5) @(posedge sys_clk);
    pair(1'b0, timer16_pkg::ADDR_COUNT, 16'h0000, timer16_pkg::ADDR_COUNT, d1, d2);
    `CHK(d1 < 16'h0010, 1'b1)
    ext.drive(1'b1, 1'b0);
    // Count clock from secondary rising edges
    cfg(16'h0000, 16'h0043);
    wr(timer16_pkg::ADDR_MODE_CTRL, 16'h0004);
    repeat (3) begin
      ext.drive(1'b0, 1'b1);
      repeat (4) @(posedge sys_clk);
      ext.drive(1'b0, 1'b0);
      repeat (4) @(posedge sys_clk);
    end
    pair(1'b0, timer16_pkg::ADDR_COUNT, 16'h0000, timer16_pkg::ADDR_COUNT, d1, d2);
    `CHK(d1, 16'h0003)
    // One-shot: trigger clears, pulse ends at match 20
    cfg(16'h0000, 16'h0000);
    wr(timer16_pkg::ADDR_CC_FIRST, 16'h0014);
    wr(timer16_pkg::ADDR_OUT_CTRL, 16'h0003);
    wr(timer16_pkg::ADDR_MODE_CTRL, 16'h0004);
    repeat (100) @(posedge sys_clk);
    wr(timer16_pkg::ADDR_OUT_CTRL, 16'h0007);
    pair(1'b0, timer16_pkg::ADDR_COUNT, 16'h0000, timer16_pkg::ADDR_COUNT, d1, d2);
    `CHK(d1 < 16'h0004, 1'b1)
    `CHK(pin_out, 1'b1)
    `CHK(pin_oe, 1'b1)
    repeat (30) @(posedge sys_clk);
    #1 `CHK(pin_out, 1'b0)
    stop_test;
  end
endmodule : test_timer16_capture_compare
`default_nettype wire
